// ---- hw/led_sink_pkg.sv ----
package led_sink_pkg;

	// Channel count and field widths
	localparam int NUM_CH = 3;
	localparam int DUTY_W = 5;
	localparam int CUR_W = 4;
	localparam int SLOT_W = 7;
	localparam int RAMP_W = 5;
	localparam int NUM_SLOTS = 5;

	// Byte offsets (all chosen here, one word each except the channel windows, 32 bytes apart)
	localparam logic [11:0] OFF_FUNC_SEL = 12'h000;
	localparam logic [11:0] OFF_SINK_EN = 12'h004;
	localparam logic [11:0] OFF_SEQ_EN = 12'h008;
	localparam logic [11:0] OFF_RAMP = 12'h00C;
	localparam logic [11:0] OFF_STATUS = 12'h010;
	localparam logic [11:0] OFF_CH_BASE = 12'h040;
	localparam logic [11:0] OFF_CH_STRIDE = 12'h020;
	// Per-channel word offsets within a channel window
	localparam logic [4:0] CH_CTRL = 5'h00;
	localparam logic [4:0] CH_SLOT01 = 5'h04;
	localparam logic [4:0] CH_SLOT23 = 5'h08;
	localparam logic [4:0] CH_PAUSE_ON = 5'h0C;

	// Field positions in channel control word
	localparam int POS_CUR = 0;
	localparam int POS_DUTY = 8;
	localparam int POS_SLOPE = 16;

	// Reset values and the 10 mA current code
	localparam logic [CUR_W-1:0] RST_CUR = 4'h0;
	localparam logic [DUTY_W-1:0] RST_DUTY = 5'h1F;
	localparam logic [CUR_W-1:0] CODE_10MA = 4'h4;

	// Timing: 125 MHz clock, slot units of 64 ms, ramp units of 8 ms
	localparam longint CLK_HZ = 125000000;
	localparam longint SLOT_UNIT_MS = 64;
	localparam longint RAMP_UNIT_MS = 8;
	localparam longint SLOT_UNIT_CYC = CLK_HZ * SLOT_UNIT_MS / 1000;
	localparam longint RAMP_UNIT_CYC = CLK_HZ * RAMP_UNIT_MS / 1000;

	// Sequencer phase within a slot
	typedef enum logic [1:0] {
		PH_RISE,
		PH_HOLD,
		PH_FALL,
		PH_REST
	} phase_t;

	// Per-channel software settings
	typedef struct packed {
		logic [CUR_W-1:0] cur;
		logic [DUTY_W-1:0] duty;
		logic slope_en;
		logic [SLOT_W-1:0] on_time;
		logic [NUM_SLOTS*SLOT_W-1:0] slots;
	} ch_cfg_t;

endpackage : led_sink_pkg

// ---- hw/led_sink_flash_sequencer.sv ----
// Summary of operation
// - A set function-select bit turns the shared pin into an LED current sink instead of GPIO.
// - Sink current is PWM gated by a five-bit duty, all ones meaning always on.
// - Each channel's DC current is set on its own between 2 mA and 20 mA.
// - A four-bit current code is decoded, code 0100b giving 10 mA.
// - A sink is active only while its bit in the sink-enable register is one.
// - Each channel has its own flash-sequencer enable that starts its sequence.
// - A sequence has four active slots and a pause slot, each 0 to 127 units of 64 ms; the code runs rise/hold/fall in the pause slot too.
// - In each slot the current ramps up, holds for the on-time, then ramps down.
// - Ramp-up and ramp-down step times are shared, each 0 to 31 units of 8 ms.
// - With slope disabled the current jumps straight to the programmed code.
// - With slope enabled the current steps toward the programmed code at the slope.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module led_sink_flash_sequencer (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pin stage controls per channel
	output logic [led_sink_pkg::NUM_CH-1:0] sink_mode,
	output logic [led_sink_pkg::NUM_CH-1:0] sink_on,
	output logic [led_sink_pkg::NUM_CH*led_sink_pkg::CUR_W-1:0] sink_level
);
	import led_sink_pkg::*;

	localparam int SLOT_CW = $clog2(int'(SLOT_UNIT_CYC) + 1);
	localparam int RAMP_CW = $clog2(int'(RAMP_UNIT_CYC) + 1);
	localparam logic [SLOT_CW-1:0] SLOT_LAST = SLOT_CW'(SLOT_UNIT_CYC - 1);
	localparam logic [RAMP_CW-1:0] RAMP_LAST = RAMP_CW'(RAMP_UNIT_CYC - 1);

	// Shared registers
	logic [NUM_CH-1:0] func_sel_q, func_sel_d;
	logic [NUM_CH-1:0] sink_en_q, sink_en_d;
	logic [NUM_CH-1:0] seq_en_q, seq_en_d;
	logic [RAMP_W-1:0] ramp_up_q, ramp_up_d;
	logic [RAMP_W-1:0] ramp_dn_q, ramp_dn_d;
	ch_cfg_t cfg_q [NUM_CH];
	ch_cfg_t cfg_d [NUM_CH];
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	// Per-channel sequencer state (current level read back in status)
	logic [CUR_W-1:0] lvl_q [NUM_CH];
	logic [DUTY_W-1:0] pwm_q [NUM_CH];
	logic [NUM_CH-1:0] on_q;

	logic acc;
	logic [1:0] ch_idx;
	logic [4:0] ch_off;
	logic ch_hit;
	assign acc = psel & penable & ~pready_q;
	assign ch_off = paddr[4:0];
	assign ch_idx = 2'((paddr - OFF_CH_BASE) >> 5);
	assign ch_hit = (paddr >= OFF_CH_BASE) &&
		(paddr < OFF_CH_BASE + 12'(NUM_CH) * OFF_CH_STRIDE);

	// Register bus decode: one wait state, answer on second access cycle
	always_comb begin
		func_sel_d = func_sel_q;
		sink_en_d = sink_en_q;
		seq_en_d = seq_en_q;
		ramp_up_d = ramp_up_q;
		ramp_dn_d = ramp_dn_q;
		cfg_d = cfg_q;
		prdata_d = 32'h0000_0000;
		pready_d = acc;
		pslverr_d = 1'b0;
		if (acc) begin
			if (ch_hit) begin
				unique case (ch_off)
					CH_CTRL: begin
						prdata_d = {15'h0000, cfg_q[ch_idx].slope_en, 3'h0, cfg_q[ch_idx].duty,
							4'h0, cfg_q[ch_idx].cur};
						if (pwrite) begin
							cfg_d[ch_idx].cur = pwdata[POS_CUR +: CUR_W];
							cfg_d[ch_idx].duty = pwdata[POS_DUTY +: DUTY_W];
							cfg_d[ch_idx].slope_en = pwdata[POS_SLOPE];
						end
					end
					CH_SLOT01: begin
						prdata_d = {17'h0, cfg_q[ch_idx].slots[SLOT_W +: SLOT_W], 1'b0,
							cfg_q[ch_idx].slots[0 +: SLOT_W]};
						if (pwrite) begin
							cfg_d[ch_idx].slots[0 +: SLOT_W] = pwdata[6:0];
							cfg_d[ch_idx].slots[SLOT_W +: SLOT_W] = pwdata[14:8];
						end
					end
					CH_SLOT23: begin
						prdata_d = {17'h0, cfg_q[ch_idx].slots[3*SLOT_W +: SLOT_W], 1'b0,
							cfg_q[ch_idx].slots[2*SLOT_W +: SLOT_W]};
						if (pwrite) begin
							cfg_d[ch_idx].slots[2*SLOT_W +: SLOT_W] = pwdata[6:0];
							cfg_d[ch_idx].slots[3*SLOT_W +: SLOT_W] = pwdata[14:8];
						end
					end
					CH_PAUSE_ON: begin
						prdata_d = {17'h0, cfg_q[ch_idx].on_time, 1'b0,
							cfg_q[ch_idx].slots[4*SLOT_W +: SLOT_W]};
						if (pwrite) begin
							cfg_d[ch_idx].slots[4*SLOT_W +: SLOT_W] = pwdata[6:0];
							cfg_d[ch_idx].on_time = pwdata[14:8];
						end
					end
					default: pslverr_d = 1'b1;
				endcase
			end else begin
				unique case (paddr)
					OFF_FUNC_SEL: begin
						prdata_d = {29'h0, func_sel_q};
						if (pwrite) func_sel_d = pwdata[NUM_CH-1:0];
					end
					OFF_SINK_EN: begin
						prdata_d = {29'h0, sink_en_q};
						if (pwrite) sink_en_d = pwdata[NUM_CH-1:0];
					end
					OFF_SEQ_EN: begin
						prdata_d = {29'h0, seq_en_q};
						if (pwrite) seq_en_d = pwdata[NUM_CH-1:0];
					end
					OFF_RAMP: begin
						prdata_d = {19'h0, ramp_dn_q, 3'h0, ramp_up_q};
						if (pwrite) begin
							ramp_up_d = pwdata[RAMP_W-1:0];
							ramp_dn_d = pwdata[8 +: RAMP_W];
						end
					end
					OFF_STATUS: prdata_d = {17'h0, on_q, lvl_q[2], lvl_q[1], lvl_q[0]};
					default: pslverr_d = 1'b1;
				endcase
			end
		end
	end

	// Register storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func_sel_q <= '0;
			sink_en_q <= '0;
			seq_en_q <= '0;
			ramp_up_q <= '0;
			ramp_dn_q <= '0;
			for (int i = 0; i < NUM_CH; i++) begin
				cfg_q[i] <= '{cur: RST_CUR, duty: RST_DUTY, slope_en: 1'b0, on_time: '0, slots: '0};
			end
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			func_sel_q <= func_sel_d;
			sink_en_q <= sink_en_d;
			seq_en_q <= seq_en_d;
			ramp_up_q <= ramp_up_d;
			ramp_dn_q <= ramp_dn_d;
			cfg_q <= cfg_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// Shared 64 ms slot tick and 8 ms ramp tick
	logic [SLOT_CW-1:0] slot_pre_q, slot_pre_d;
	logic [RAMP_CW-1:0] ramp_pre_q, ramp_pre_d;
	logic slot_tick, ramp_tick;
	assign slot_tick = (slot_pre_q == SLOT_LAST);
	assign ramp_tick = (ramp_pre_q == RAMP_LAST);
	always_comb begin
		slot_pre_d = slot_tick ? '0 : slot_pre_q + 1'b1;
		ramp_pre_d = ramp_tick ? '0 : ramp_pre_q + 1'b1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_pre_q <= '0;
			ramp_pre_q <= '0;
		end else begin
			slot_pre_q <= slot_pre_d;
			ramp_pre_q <= ramp_pre_d;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			phase_t ph_q, ph_d;
			logic [2:0] slot_q, slot_d;
			logic [SLOT_W-1:0] sl_cnt_q, sl_cnt_d;
			logic [SLOT_W-1:0] on_cnt_q, on_cnt_d;
			logic [RAMP_W-1:0] st_cnt_q, st_cnt_d;
			logic [CUR_W-1:0] lvl_d;
			logic [DUTY_W-1:0] pwm_d;
			logic on_d;
			// Sequencer was running last cycle
			logic run_q, run_d;
			logic [SLOT_W-1:0] slot_len;
			logic [RAMP_W-1:0] step_len;
			logic step;
			assign slot_len = cfg_q[g].slots[slot_q*SLOT_W +: SLOT_W];
			assign step_len = (ph_q == PH_FALL) ? ramp_dn_q : ramp_up_q;

			// Sequencer: slots 1..4 then pause, rise/hold/fall inside each slot
			always_comb begin
				ph_d = ph_q;
				slot_d = slot_q;
				sl_cnt_d = sl_cnt_q;
				on_cnt_d = on_cnt_q;
				st_cnt_d = st_cnt_q;
				lvl_d = lvl_q[g];
				step = 1'b0;
				run_d = seq_en_q[g];
				if (ramp_tick) begin
					if (st_cnt_q >= step_len) begin
						st_cnt_d = '0;
						step = 1'b1;
					end else begin
						st_cnt_d = st_cnt_q + 1'b1;
					end
				end
				if (!seq_en_q[g]) begin
					ph_d = PH_RISE;
					slot_d = 3'h0;
					sl_cnt_d = '0;
					on_cnt_d = '0;
					lvl_d = cfg_q[g].cur;
				end else begin
					unique case (ph_q)
						PH_RISE: begin
							if (!cfg_q[g].slope_en || lvl_q[g] >= cfg_q[g].cur) begin
								lvl_d = cfg_q[g].cur;
								ph_d = PH_HOLD;
							end else if (step) begin
								lvl_d = lvl_q[g] + 1'b1;
							end
						end
						PH_HOLD: begin
							if (slot_tick) on_cnt_d = on_cnt_q + 1'b1;
							if (on_cnt_q >= cfg_q[g].on_time) begin
								on_cnt_d = '0;
								ph_d = PH_FALL;
							end
						end
						PH_FALL: begin
							if (!cfg_q[g].slope_en || lvl_q[g] == '0) begin
								lvl_d = '0;
								ph_d = PH_REST;
							end else if (step) begin
								lvl_d = lvl_q[g] - 1'b1;
							end
						end
						PH_REST: lvl_d = '0;
					endcase
					// Fresh start from zero
					// Without this the first rise would see the constant level and skip the ramp
					if (!run_q) begin
						lvl_d = '0;
						ph_d = PH_RISE;
					end
					// Slot length in 64 ms units
					if (slot_tick) sl_cnt_d = sl_cnt_q + 1'b1;
					if (sl_cnt_q >= slot_len) begin
						sl_cnt_d = '0;
						on_cnt_d = '0;
						ph_d = PH_RISE;
						lvl_d = '0;
						slot_d = (slot_q == 3'(NUM_SLOTS - 1)) ? 3'h0 : slot_q + 3'h1;
					end
				end
				pwm_d = pwm_q[g] + 1'b1;
				on_d = func_sel_q[g] && sink_en_q[g] && (lvl_d != '0) &&
					((cfg_q[g].duty == RST_DUTY) || (pwm_q[g] < cfg_q[g].duty));
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ph_q <= PH_RISE;
					run_q <= 1'b0;
					slot_q <= 3'h0;
					sl_cnt_q <= '0;
					on_cnt_q <= '0;
					st_cnt_q <= '0;
					lvl_q[g] <= '0;
					pwm_q[g] <= '0;
					on_q[g] <= 1'b0;
					sink_mode[g] <= 1'b0;
					sink_level[g*CUR_W +: CUR_W] <= '0;
				end else begin
					ph_q <= ph_d;
					run_q <= run_d;
					slot_q <= slot_d;
					sl_cnt_q <= sl_cnt_d;
					on_cnt_q <= on_cnt_d;
					st_cnt_q <= st_cnt_d;
					lvl_q[g] <= lvl_d;
					pwm_q[g] <= pwm_d;
					on_q[g] <= on_d;
					sink_mode[g] <= func_sel_q[g];
					// Per-channel current code to analog stage
					sink_level[g*CUR_W +: CUR_W] <= lvl_d;
				end
			end
		end
	endgenerate
	assign sink_on = on_q;

endmodule : led_sink_flash_sequencer
`default_nettype wire

// ---- bench/led_sink_flash_sequencer_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module led_sink_flash_sequencer_props (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pin stage
	input wire logic [led_sink_pkg::NUM_CH-1:0] sink_mode,
	input wire logic [led_sink_pkg::NUM_CH-1:0] sink_on,
	input wire logic [led_sink_pkg::NUM_CH*led_sink_pkg::CUR_W-1:0] sink_level
);
	import led_sink_pkg::*;
	logic [NUM_CH-1:0] func_q, func_d, en_q, en_d, live;
	logic wr_ok;
	// Shadow of select and enable registers as written on the bus
	assign wr_ok = psel & penable & pready & pwrite & ~pslverr;
	assign live = func_q & en_q;
	always_comb begin
		func_d = func_q;
		en_d = en_q;
		if (wr_ok && paddr == OFF_FUNC_SEL) func_d = pwdata[NUM_CH-1:0];
		if (wr_ok && paddr == OFF_SINK_EN) en_d = pwdata[NUM_CH-1:0];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func_q <= '0;
			en_q <= '0;
		end else begin
			func_q <= func_d;
			en_q <= en_d;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_take; psel && penable && !pready |=> pready; endproperty
	property p_pulse; pready |=> !pready; endproperty
	property p_held; pready |-> psel && penable; endproperty
	property p_cause; pready |-> $past(psel && penable && !pready); endproperty
	property p_err_ready; pslverr |-> pready; endproperty
	property p_err_data; pslverr |-> prdata == 32'h0; endproperty
	property p_mode;
		func_q == $past(func_q) && func_q == $past(func_q, 2) |-> sink_mode == func_q;
	endproperty
	property p_on_gate; (sink_on & ~live & ~$past(live)) == '0; endproperty
	a_take: assert property (p_take) else $error("no answer after access");
	a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
	a_held: assert property (p_held) else $error("ready outside access");
	a_cause: assert property (p_cause) else $error("ready without access");
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	a_err_data: assert property (p_err_data) else $error("error with data");
	a_mode: assert property (p_mode) else $error("pin mode not select");
	a_on_gate: assert property (p_on_gate) else $error("sink on while off");
	c_err: cover property (pslverr);
	c_on: cover property (sink_on[0]);
	c_mode: cover property (&sink_mode);
endmodule : led_sink_flash_sequencer_props
bind led_sink_flash_sequencer led_sink_flash_sequencer_props u_props (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sink_mode, .sink_on,
	.sink_level);
`default_nettype wire

// ---- bench/led_sink_flash_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module led_sink_flash_sequencer_tb_top;
	import led_sink_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er;
	logic [NUM_CH-1:0] sink_mode, sink_on;
	logic [NUM_CH*CUR_W-1:0] sink_level;
	logic [3:0] cur [NUM_CH];
	int fails = 0;
	int compares = 0;
	int cnt [NUM_CH];
	int d;
	// Clock at 125 MHz
	always #4 pclk = ~pclk;
	led_sink_flash_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .sink_mode, .sink_on, .sink_level);
	// Verdict and end of run
	task automatic end_of_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_pin(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: pins %h expected %h", $time, got, exp);
		end
	endtask : chk_pin
	// One APB transfer, waiting for the answer
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Count sink conduction over two PWM periods
	task automatic count_on;
		cnt = '{0, 0, 0};
		repeat (64) begin
			@(posedge pclk);
			for (int n = 0; n < NUM_CH; n++) cnt[n] += (sink_on[n] === 1'b1);
		end
	endtask : count_on
	function automatic logic [31:0] ctrl_word(logic [3:0] c, logic [4:0] du, logic s);
		return {15'h0, s, 3'h0, du, 4'h0, c};
	endfunction : ctrl_word
	function automatic logic [11:0] ch_addr(int n, logic [4:0] o);
		return 12'(OFF_CH_BASE + OFF_CH_STRIDE * n + o);
	endfunction : ch_addr
	// Main sequence
	initial begin
		void'($urandom(32'h0A65));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int n = 0; n < NUM_CH; n++) begin
			apb(1'b0, ch_addr(n, CH_CTRL), 32'h0);
			chk_reg(rd, ctrl_word(RST_CUR, RST_DUTY, 1'b0));
		end
		apb(1'b0, OFF_SINK_EN, 32'h0);
		chk_reg(rd, 32'h0);
		chk_pin({6'h0, sink_mode, sink_on}, 12'h000);
		apb(1'b1, 12'h0FC, 32'hFFFFFFFF);
		chk_pin({11'h0, er}, 12'h001);
		$display("test reset and unmapped done");
		apb(1'b1, OFF_FUNC_SEL, 32'h7);
		apb(1'b1, ch_addr(0, CH_CTRL), ctrl_word(CODE_10MA, 5'h1F, 1'b0));
		apb(1'b1, OFF_SINK_EN, 32'h1);
		count_on();
		chk_pin({9'h0, sink_mode}, 12'h007);
		chk_pin({4'h0, sink_level[3:0], 4'(cnt[0])}, {4'h0, CODE_10MA, 4'h0});
		chk_reg(32'(cnt[0]), 32'd64);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk_reg(rd, {17'h0, 3'h1, 8'h00, CODE_10MA});
		$display("test constant current done");
		for (int t = 0; t < 4; t++) begin
			d = (t == 0) ? 0 : (t == 1) ? 30 : $urandom_range(29, 1);
			for (int n = 0; n < NUM_CH; n++) begin
				cur[n] = 4'($urandom_range(15, 1));
				apb(1'b1, ch_addr(n, CH_CTRL), ctrl_word(cur[n], (n == 0) ? 5'(d) : 5'h1F, 1'b0));
			end
			apb(1'b1, OFF_SINK_EN, 32'h5);
			count_on();
			chk_reg(32'(cnt[0]), 32'(2 * d));
			chk_reg(32'(cnt[1] + cnt[2]), 32'd64);
			chk_pin(sink_level, {cur[2], cur[1], cur[0]});
			apb(1'b0, OFF_STATUS, 32'h0);
			chk_pin(rd[11:0], {cur[2], cur[1], cur[0]});
			apb(1'b0, ch_addr(0, CH_CTRL), 32'h0);
			chk_reg(rd, ctrl_word(cur[0], 5'(d), 1'b0));
		end
		$display("test duty and current done");
		apb(1'b1, ch_addr(0, CH_CTRL), ctrl_word(cur[0], 5'h1F, 1'b1));
		apb(1'b1, ch_addr(0, CH_SLOT01), 32'h0505);
		apb(1'b1, OFF_SEQ_EN, 32'h1);
		repeat (20) @(posedge pclk);
		chk_pin(sink_level, {cur[2], cur[1], 4'h0});
		apb(1'b1, OFF_SEQ_EN, 32'h0);
		repeat (3) @(posedge pclk);
		chk_pin(sink_level, {cur[2], cur[1], cur[0]});
		apb(1'b1, OFF_FUNC_SEL, 32'h0);
		repeat (3) @(posedge pclk);
		chk_pin({6'h0, sink_mode, sink_on}, 12'h000);
		$display("test sequencer and select done");
		end_of_test();
	end
	// Watchdog
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		end_of_test();
	end
endmodule : led_sink_flash_sequencer_tb_top
`default_nettype wire
